// [logic/lpwk_ctrl.sv]
// low-power mode sequencer and external wake line control
// assumes cpu strobes are on clk; port pins are asynchronous
// ****************************************************************
// top level
// ****************************************************************
//
// Implementation choices: the register addresses and the address-and-strobe port.
module lpwk_ctrl #(
  parameter int STARTUP_CYC = lpwk_pkg::STARTUP_LONG // start-up wait
) (
  input wire logic clk, // master clock
  input wire logic resetn, // async reset, active low
  input wire logic [3:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic wfi_exec, // wait_for_irq_instruction pulse
  input wire logic halt_exec, // halt instruction pulse
  input wire logic irq_mask_in, // cpu interrupt mask bit
  input wire logic other_irq, // any non-external irq pending
  input wire logic halt_wake_irq, // other irq able to exit halt
  input wire logic [3:0] irq_ack, // service entry per line
  input wire logic lite_timebase_irq_enable, // timer enable
  input wire logic overflow_irq_enable, // reload timer enable
  input wire logic timer_clock_sel_hi, // reload timer clock select
  input wire logic timer_clock_sel_lo, // reload timer clock select
  input wire logic auto_wake_enable, // auto-wake feature enable
  input wire logic watchdog_in_halt_option, // halt makes wdg reset
  input wire logic watchdog_active, // watchdog running
  input wire logic [7:0] port_a, // port A pins, async
  input wire logic [6:0] port_b, // port B pins, async
  output logic [3:0] ext_irq_req, // wake_line_zero..three requests
  output logic irq_mask_clr, // force cpu mask to zero
  output logic cpu_run, // cpu clock enabled
  output logic cpu_clk_en, // cpu clock enable pulse
  output logic periph_clk_en, // peripheral clock enable pulse
  output logic timer_clk_en, // wake-up timer clock enable
  output logic osc_on, // main oscillator enable
  output logic watchdog_reset, // watchdog reset request pulse
  output logic [5:0] power_mode // current mode, one-hot
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] sens_r, psel_r;
  logic slow_r;
  logic [7:0] rdata_r;
  logic [3:0] trig_chg;
  logic [3:0] line_pin;
  logic [3:0] line_req;
  logic [4:0] div_r;
  logic div_tick;
  logic [12:0] start_r;
  logic active_cond, halt_wake, any_irq;
  lpwk_pkg::lpwk_mode_e mode_r;

  localparam logic [12:0] START_LAST = 13'(STARTUP_CYC - 1);

  // sensitivity writes gated by the cpu mask
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sens_r <= lpwk_pkg::SENS_RST;
    end else if (reg_wr && reg_addr == lpwk_pkg::ADDR_SENS &&
                 irq_mask_in) begin
      sens_r <= reg_wdata;
    end
  end

  // a field counts as changed only if the accepted write alters it
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      trig_chg[i] = reg_wr && reg_addr == lpwk_pkg::ADDR_SENS &&
        irq_mask_in && (reg_wdata[2*i +: 2] != sens_r[2*i +: 2]);
    end
  end

  // pin routing and clock control registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      psel_r <= lpwk_pkg::PSEL_RST;
      slow_r <= 1'b0;
    end else if (reg_wr && reg_addr == lpwk_pkg::ADDR_PSEL) begin
      psel_r <= reg_wdata;
    end else if (reg_wr && reg_addr == lpwk_pkg::ADDR_CLK) begin
      slow_r <= reg_wdata[lpwk_pkg::CLK_SLOW_BIT];
    end
  end

  // read port; unmapped addresses read zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == lpwk_pkg::ADDR_SENS) begin
        rdata_r <= sens_r;
      end else if (reg_addr == lpwk_pkg::ADDR_PSEL) begin
        rdata_r <= psel_r;
      end else if (reg_addr == lpwk_pkg::ADDR_CLK) begin
        rdata_r <= {7'h00, slow_r};
      end else if (reg_addr == lpwk_pkg::ADDR_STAT) begin
        rdata_r <= {line_req, mode_r[3:0]};
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end
  assign reg_rdata = rdata_r;

  // ****************************************************************
  // pin routing and wake lines
  // ****************************************************************
  // line three code 11 has no pin; it reads as idle high
  always_comb begin
    line_pin[0] = port_a[{1'b0, psel_r[1:0]}];
    line_pin[1] = port_a[{1'b1, psel_r[3:2]}];
    line_pin[2] = port_b[3'(psel_r[5:4]) + 3'h3];
    line_pin[3] = (psel_r[7:6] == 2'h3) ? 1'b1 :
      port_b[{1'b0, psel_r[7:6]}];
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_line
      lpwk_line u_line (
        .clk(clk),
        .resetn(resetn),
        .pin(line_pin[g]),
        .trig(sens_r[2*g +: 2]),
        .trig_chg(trig_chg[g]),
        .ack(irq_ack[g]),
        .req(line_req[g])
      );
    end
  endgenerate
  assign ext_irq_req = line_req;

  // ****************************************************************
  // clock divider
  // ****************************************************************
  // one counter; the tick period is 2 or 32 master cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= 5'h00;
    end else if (div_tick) begin
      div_r <= 5'h00;
    end else begin
      div_r <= div_r + 5'h01;
    end
  end
  assign div_tick = slow_r ? (div_r == 5'(lpwk_pkg::SLOW_DIV - 1))
                           : (div_r >= 5'(lpwk_pkg::RUN_DIV - 1));

  // ****************************************************************
  // power mode sequencer
  // ****************************************************************
  assign active_cond = lite_timebase_irq_enable |
    (overflow_irq_enable & ~timer_clock_sel_hi & timer_clock_sel_lo);
  assign any_irq = (|line_req) | other_irq;
  // line two routed to B4 cannot wake any halt mode, active halt with the oscillator on included
  assign halt_wake = halt_wake_irq | line_req[0] | line_req[1] |
    line_req[3] | (line_req[2] &
    (psel_r[5:4] != lpwk_pkg::L2_NOHALT_CODE));

  // mode transitions; auto-wake halt is tracked, its timer lives outside
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= lpwk_pkg::LPWK_RUN;
      start_r <= 13'h0000;
    end else begin
      case (mode_r)
        lpwk_pkg::LPWK_RUN: begin
          if (wfi_exec) begin
            mode_r <= lpwk_pkg::LPWK_WAIT;
          end else if (halt_exec && !(watchdog_in_halt_option &&
                       watchdog_active && !active_cond)) begin
            if (active_cond) begin
              mode_r <= lpwk_pkg::LPWK_AHALT;
            end else if (auto_wake_enable) begin
              mode_r <= lpwk_pkg::LPWK_AWU;
            end else begin
              mode_r <= lpwk_pkg::LPWK_HALT;
            end
          end
        end
        lpwk_pkg::LPWK_WAIT: begin
          if (any_irq) begin
            mode_r <= lpwk_pkg::LPWK_RUN;
          end
        end
        lpwk_pkg::LPWK_HALT, lpwk_pkg::LPWK_AWU: begin
          if (halt_wake) begin
            mode_r <= lpwk_pkg::LPWK_START;
            start_r <= 13'h0000;
          end
        end
        lpwk_pkg::LPWK_AHALT: begin
          if (halt_wake) begin
            mode_r <= lpwk_pkg::LPWK_RUN;
          end
        end
        lpwk_pkg::LPWK_START: begin
          if (start_r == START_LAST) begin
            mode_r <= lpwk_pkg::LPWK_RUN;
          end else begin
            start_r <= start_r + 13'h0001;
          end
        end
        default: mode_r <= lpwk_pkg::LPWK_RUN;
      endcase
    end
  end

  // watchdog reset when halt is refused by the option
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= mode_r == lpwk_pkg::LPWK_RUN && !wfi_exec &&
        halt_exec && watchdog_in_halt_option && watchdog_active &&
        !active_cond;
    end
  end

  // ****************************************************************
  // clock gating outputs
  // ****************************************************************
  // mask clear stands for the whole low-power stay
  assign irq_mask_clr = mode_r == lpwk_pkg::LPWK_WAIT ||
    mode_r == lpwk_pkg::LPWK_HALT || mode_r == lpwk_pkg::LPWK_AWU ||
    mode_r == lpwk_pkg::LPWK_AHALT;
  assign cpu_run = mode_r == lpwk_pkg::LPWK_RUN;
  assign cpu_clk_en = cpu_run & div_tick;
  assign periph_clk_en = (cpu_run || mode_r == lpwk_pkg::LPWK_WAIT) &
    div_tick;
  assign timer_clk_en = (cpu_run || mode_r == lpwk_pkg::LPWK_WAIT ||
    mode_r == lpwk_pkg::LPWK_AHALT) & div_tick;
  assign osc_on = !(mode_r == lpwk_pkg::LPWK_HALT ||
    mode_r == lpwk_pkg::LPWK_AWU);
  assign power_mode = mode_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_sens_locked: assert property (@(posedge clk) disable iff (!resetn)
    reg_wr && reg_addr == lpwk_pkg::ADDR_SENS && !irq_mask_in
    |=> $stable(sens_r)) else $error("sensitivity written while unmasked");
  a_retune_clears: assert property (@(posedge clk) disable iff (!resetn)
    trig_chg[0] |=> !g_line[0].u_line.pend_r)
    else $error("retune left request pending");
  a_halt_plain: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == lpwk_pkg::LPWK_RUN && halt_exec && !wfi_exec &&
    !active_cond && !auto_wake_enable && !watchdog_in_halt_option
    |=> mode_r == lpwk_pkg::LPWK_HALT && !osc_on)
    else $error("plain halt not entered");
  a_ahalt_enter: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == lpwk_pkg::LPWK_RUN && halt_exec && !wfi_exec && active_cond
    |=> mode_r == lpwk_pkg::LPWK_AHALT ##1 !watchdog_reset)
    else $error("active halt not entered");
  a_start_delay: assert property (@(posedge clk) disable iff (!resetn)
    $rose(mode_r == lpwk_pkg::LPWK_START)
    |-> !cpu_run [*8]) else $error("start-up wait cut short");
  a_ahalt_fast: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == lpwk_pkg::LPWK_AHALT && halt_wake
    |=> cpu_run) else $error("active halt exit delayed");
  a_b4_blind: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == lpwk_pkg::LPWK_HALT && psel_r[5:4] == 2'h1 &&
    line_req == 4'h4 && !halt_wake_irq |=> mode_r == lpwk_pkg::LPWK_HALT)
    else $error("B4 woke halt");
  a_wait_exit: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == lpwk_pkg::LPWK_WAIT && any_irq |=> cpu_run && !irq_mask_clr)
    else $error("wait exit missed");
  a_slow_rate: assert property (@(posedge clk) disable iff (!resetn)
    slow_r && $past(slow_r) && cpu_clk_en |=> !cpu_clk_en [*8])
    else $error("slow clock too fast");
  c_wait: cover property (@(posedge clk) disable iff (!resetn)
    mode_r == lpwk_pkg::LPWK_WAIT ##[1:20] cpu_run);
  c_halt_wake: cover property (@(posedge clk) disable iff (!resetn)
    mode_r == lpwk_pkg::LPWK_START ##1 mode_r == lpwk_pkg::LPWK_START);
  c_ahalt: cover property (@(posedge clk) disable iff (!resetn)
    mode_r == lpwk_pkg::LPWK_AHALT ##1 cpu_run);

  // mode entry and stay checks; enables must follow the mode at once
  a_wfi_enter: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == lpwk_pkg::LPWK_RUN && wfi_exec |=> mode_r ==
    lpwk_pkg::LPWK_WAIT && irq_mask_clr) else $error("wait not entered");
  a_wait_cpu_off: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == lpwk_pkg::LPWK_WAIT |-> !cpu_clk_en && !cpu_run)
    else $error("cpu clocked in wait");
  a_wait_stay: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == lpwk_pkg::LPWK_WAIT && !any_irq |=> mode_r ==
    lpwk_pkg::LPWK_WAIT) else $error("wait left without irq");
  a_halt_mask: assert property (@(posedge clk) disable iff (!resetn)
    (mode_r == lpwk_pkg::LPWK_HALT || mode_r == lpwk_pkg::LPWK_AHALT ||
    mode_r == lpwk_pkg::LPWK_AWU) |-> irq_mask_clr)
    else $error("mask kept in halt");
  a_halt_quiet: assert property (@(posedge clk) disable iff (!resetn)
    (mode_r == lpwk_pkg::LPWK_HALT || mode_r == lpwk_pkg::LPWK_AWU) |->
    !cpu_clk_en && !periph_clk_en && !timer_clk_en && !osc_on)
    else $error("clock running in halt");
  a_ahalt_osc: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == lpwk_pkg::LPWK_AHALT |-> osc_on && !periph_clk_en &&
    !cpu_clk_en) else $error("active halt clocks wrong");
  a_start_end: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == lpwk_pkg::LPWK_START && start_r == START_LAST |=> cpu_run)
    else $error("start-up wait overran");
  a_wdg_refuse: assert property (@(posedge clk) disable iff (!resetn)
    watchdog_reset |-> cpu_run) else $error("halt taken with reset");

  // slow-wait and the refused halt are the rarer paths worth seeing
  c_slow_wait: cover property (@(posedge clk) disable iff (!resetn)
    mode_r == lpwk_pkg::LPWK_WAIT && slow_r && periph_clk_en);
  c_refused: cover property (@(posedge clk) disable iff (!resetn)
    watchdog_reset);
endmodule

// [logic/lpwk_pkg.sv]
// package for the low-power mode and wake line controller
// assumes one 250 MHz master clock and the plain register port
package lpwk_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] ADDR_SENS = 4'h0; // ext_irq_sensitivity
  localparam logic [3:0] ADDR_PSEL = 4'h1; // ext_irq_pin_select
  localparam logic [3:0] ADDR_CLK = 4'h2; // main_clock_ctrl_reg
  localparam logic [3:0] ADDR_STAT = 4'h3; // mode and pending status
  localparam logic [7:0] SENS_RST = 8'h00;
  localparam logic [7:0] PSEL_RST = 8'h0C;
  localparam int CLK_SLOW_BIT = 0; // slow_clock_select
  // ****************************************************************
  // trigger types and pin codes
  // ****************************************************************
  localparam logic [1:0] TRIG_FALL_LOW = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [1:0] TRIG_BOTH = 2'h3;
  localparam logic [1:0] L2_NOHALT_CODE = 2'h1; // port B pin 4
  // ****************************************************************
  // clock division and start-up delay
  // ****************************************************************
  localparam int RUN_DIV = 2;
  localparam int SLOW_DIV = 32;
  localparam int STARTUP_SHORT = 256;
  localparam int STARTUP_LONG = 4096;
  // one-hot power modes
  typedef enum logic [5:0] {
    LPWK_RUN = 6'h01,
    LPWK_WAIT = 6'h02,
    LPWK_HALT = 6'h04,
    LPWK_AHALT = 6'h08,
    LPWK_START = 6'h10,
    LPWK_AWU = 6'h20
  } lpwk_mode_e;
endpackage

// [logic/lpwk_line.sv]
// one external wake line: pin synchroniser, trigger decode, pending latch
// assumes pin input is asynchronous to clk
module lpwk_line (
  input wire logic clk, // master clock
  input wire logic resetn, // async reset, active low
  input wire logic pin, // selected pin, async
  input wire logic [1:0] trig, // trigger type
  input wire logic trig_chg, // sensitivity of this line changed by a write
  input wire logic ack, // cpu entered the service routine
  output logic req // request to the cpu
);
  logic s1_r, s2_r, s3_r, pend_r, edge_hit;

  // two-stage synchroniser, then one stage of history for edges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // sensitivity decode
  always_comb begin
    case (trig)
      lpwk_pkg::TRIG_RISE: edge_hit = s2_r & ~s3_r;
      lpwk_pkg::TRIG_FALL: edge_hit = ~s2_r & s3_r;
      lpwk_pkg::TRIG_BOTH: edge_hit = s2_r ^ s3_r;
      default: edge_hit = ~s2_r & s3_r;
    endcase
  end

  // edge latch; a new edge wins over the acknowledge, a retune clears
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= 1'b0;
    end else if (trig_chg) begin
      pend_r <= 1'b0;
    end else if (edge_hit) begin
      pend_r <= 1'b1;
    end else if (ack) begin
      pend_r <= 1'b0;
    end
  end

  // low level counts directly while it lasts
  assign req = pend_r |
    ((trig == lpwk_pkg::TRIG_FALL_LOW) & ~s2_r & ~trig_chg);
endmodule

// [testbench/lpwk_cpu_model.sv]
// cpu core stand-in: takes wake requests and owns the interrupt mask
// assumes lpwk_ctrl on the same clk; bench sets and clears the mask
module lpwk_cpu_model (
  input wire logic clk, // master clock
  input wire logic resetn, // async reset, active low
  input wire logic [3:0] ext_irq_req, // requests from the block
  input wire logic [5:0] power_mode, // current mode, one-hot
  input wire logic irq_mask_clr, // block forces mask low
  input wire logic sw_mask_set, // software sets mask
  input wire logic sw_mask_clr, // software clears mask
  input wire logic [3:0] ack_dly, // cycles before service entry
  output logic [3:0] irq_ack, // service entry per line
  output logic irq_mask // interrupt mask bit
);
  // ****************************
  // service entry
  // ****************************
  logic [3:0] wait_r;
  logic [3:0] first_req;
  // lowest line wins, as a fixed priority would
  assign first_req = ext_irq_req & (~ext_irq_req + 4'h1);
  // mask set on entry, so one request is taken per unmask
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask <= 1'b1;
      wait_r <= 4'h0;
      irq_ack <= 4'h0;
    end else begin
      irq_ack <= 4'h0;
      wait_r <= 4'h0;
      if (irq_mask_clr || sw_mask_clr) begin
        irq_mask <= 1'b0;
      end else if (sw_mask_set) begin
        irq_mask <= 1'b1;
      end
      if (!irq_mask && first_req != 4'h0 &&
          power_mode == lpwk_pkg::LPWK_RUN) begin
        // slow answer when ack_dly is above zero
        if (wait_r == ack_dly) begin
          irq_ack <= first_req;
          irq_mask <= 1'b1;
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end
    end
  end
endmodule

// [testbench/tb_top.sv]
// bench for the low-power mode and wake line controller
// assumes lpwk_ctrl and the cpu stand-in; clk 250 MHz
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SU = 16; // short start-up wait keeps the run brief
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0, wfi_exec = 1'b0, halt_exec = 1'b0;
  logic other_irq = 1'b0, hwake = 1'b0, lt = 1'b0, ov = 1'b0;
  logic ch = 1'b0, cl = 1'b0, awu = 1'b0, wopt = 1'b0, wact = 1'b0;
  logic sw_set = 1'b0, sw_clr = 1'b0;
  logic [3:0] ack_dly = 4'h0;
  logic [7:0] port_a = 8'hFF;
  logic [6:0] port_b = 7'h7F;
  logic [3:0] ext_irq_req, irq_ack;
  logic [5:0] power_mode;
  logic irq_mask, irq_mask_clr, cpu_run, cpu_clk_en, periph_clk_en;
  logic timer_clk_en, osc_on, watchdog_reset;
  int err_count = 0, check_count = 0, nc, np, nt, nw, k;
  // ****************************
  // clock and instances
  // ****************************
  always #2 clk = ~clk;
  lpwk_ctrl #(.STARTUP_CYC(SU)) lpwk_ctrl_inst (.clk(clk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wfi_exec(wfi_exec), .halt_exec(halt_exec), .irq_mask_in(irq_mask),
    .other_irq(other_irq), .halt_wake_irq(hwake), .irq_ack(irq_ack),
    .lite_timebase_irq_enable(lt), .overflow_irq_enable(ov),
    .timer_clock_sel_hi(ch), .timer_clock_sel_lo(cl),
    .auto_wake_enable(awu), .watchdog_in_halt_option(wopt),
    .watchdog_active(wact), .port_a(port_a), .port_b(port_b),
    .ext_irq_req(ext_irq_req), .irq_mask_clr(irq_mask_clr),
    .cpu_run(cpu_run), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .timer_clk_en(timer_clk_en),
    .osc_on(osc_on), .watchdog_reset(watchdog_reset),
    .power_mode(power_mode));
  lpwk_cpu_model lpwk_cpu_model_inst (.clk(clk), .resetn(resetn),
    .ext_irq_req(ext_irq_req), .power_mode(power_mode),
    .irq_mask_clr(irq_mask_clr), .sw_mask_set(sw_set),
    .sw_mask_clr(sw_clr), .ack_dly(ack_dly), .irq_ack(irq_ack),
    .irq_mask(irq_mask));
  // ****************************
  // tasks
  // ****************************
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand from the cycle after the strobe until the next read
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic msk(input logic v);
    @(posedge clk);
    sw_set <= v;
    sw_clr <= !v;
    @(posedge clk);
    sw_set <= 1'b0;
    sw_clr <= 1'b0;
  endtask
  // unmask long enough for the cpu to take one request
  task automatic serve();
    msk(1'b0);
    cyc(10);
    msk(1'b1);
  endtask
  // index 0..7 is port A, 8..14 port B
  task automatic pin(input int i, input logic v);
    @(posedge clk);
    if (i < 8) port_a[i] <= v;
    else port_b[i-8] <= v;
  endtask
  task automatic ex(input logic w);
    @(posedge clk);
    wfi_exec <= w;
    halt_exec <= !w;
    @(posedge clk);
    wfi_exec <= 1'b0;
    halt_exec <= 1'b0;
  endtask
  task automatic wake(input logic h);
    @(posedge clk);
    other_irq <= !h;
    hwake <= h;
    @(posedge clk);
    other_irq <= 1'b0;
    hwake <= 1'b0;
    #1;
  endtask
  // counts enable and reset pulses, first sample in the current cycle
  task automatic cnt(input int n);
    nc = 0; np = 0; nt = 0; nw = 0;
    repeat (n) begin
      #1;
      nc += (cpu_clk_en === 1'b1);
      np += (periph_clk_en === 1'b1);
      nt += (timer_clk_en === 1'b1);
      nw += (watchdog_reset === 1'b1);
      @(posedge clk);
    end
    #1;
  endtask
  task automatic results();
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************
  // tests
  // ****************************
  initial begin
    cyc(3);
    resetn <= 1'b1;
    rd(lpwk_pkg::ADDR_SENS); chk(d, 8'h00);
    rd(lpwk_pkg::ADDR_PSEL); chk(d, 8'h0C);
    rd(4'hF); chk(d, 8'h00);
    rd(lpwk_pkg::ADDR_STAT); chk(d, 8'h01);
    wr(lpwk_pkg::ADDR_SENS, 8'h55);
    rd(lpwk_pkg::ADDR_SENS); chk(d, 8'h55);
    msk(1'b0);
    wr(lpwk_pkg::ADDR_SENS, 8'hAA);
    rd(lpwk_pkg::ADDR_SENS); chk(d, 8'h55);
    msk(1'b1);
    // every trigger code on line zero: fall then rise
    for (int c = 0; c < 4; c++) begin
      wr(lpwk_pkg::ADDR_SENS, {6'h15, c[1:0]});
      pin(0, 1'b0); cyc(8);
      chk(ext_irq_req[0], 4'b1101 >> c & 1);
      serve(); chk(ext_irq_req[0], c == 0);
      pin(0, 1'b1); cyc(8);
      chk(ext_irq_req[0], 4'b1010 >> c & 1);
      serve();
    end
    // every pin code of every line, slow service
    ack_dly <= 4'h5;
    wr(lpwk_pkg::ADDR_SENS, 8'hFF);
    for (int l = 0; l < 4; l++) for (int c = 0; c < 4; c++) begin
      if (l != 3 || c != 3) begin
        k = (l == 0) ? c : (l == 1) ? 4 + c : (l == 2) ? 11 + c : 8 + c;
        wr(lpwk_pkg::ADDR_PSEL, 8'(c << (2 * l)));
        pin(k, 1'b0); cyc(8);
        chk(ext_irq_req, 4'h1 << l);
        pin(k, 1'b1); cyc(8); serve();
        chk(ext_irq_req, 4'h0);
      end
    end
    ack_dly <= 4'h0;
    // trigger rewrite drops a latched request
    wr(lpwk_pkg::ADDR_PSEL, 8'h1C);
    wr(lpwk_pkg::ADDR_SENS, 8'h32);
    pin(0, 1'b0); cyc(8); chk(ext_irq_req[0], 1'b1);
    wr(lpwk_pkg::ADDR_SENS, 8'h33); cyc(1);
    chk(ext_irq_req[0], 1'b0);
    pin(0, 1'b1); cyc(8); serve();
    // run, slow and slow-wait clock rates
    cnt(64); chk(8'(nc), 8'd32);
    wr(lpwk_pkg::ADDR_CLK, 8'h01); cyc(40);
    cnt(64); chk(8'(nc), 8'd2);
    ex(1'b1); #1 chk(power_mode, lpwk_pkg::LPWK_WAIT);
    chk({cpu_run, irq_mask_clr}, 2'b01);
    cnt(64); chk(8'(nc * 16 + np), 8'd2);
    wake(1'b0); chk(power_mode, lpwk_pkg::LPWK_RUN);
    msk(1'b1);
    wr(lpwk_pkg::ADDR_CLK, 8'h00); cyc(40);
    cnt(64); chk(8'(nc), 8'd32);
    // plain halt; line two on port B pin 4 must not wake it
    ex(1'b0); #1 chk(power_mode, lpwk_pkg::LPWK_HALT);
    chk({osc_on, irq_mask_clr}, 2'b01);
    pin(12, 1'b0); cnt(12); chk(8'(nc + np), 8'd0);
    chk(power_mode, lpwk_pkg::LPWK_HALT);
    pin(0, 1'b0);
    k = 0;
    while (power_mode !== lpwk_pkg::LPWK_START && k < 12) begin
      @(posedge clk); #1 k++;
    end
    k = 0;
    while (power_mode === lpwk_pkg::LPWK_START && k < 40) begin
      @(posedge clk); #1 k++;
    end
    chk(8'(k), 8'(SU));
    pin(0, 1'b1); pin(12, 1'b1); cyc(8); msk(1'b1);
    wr(lpwk_pkg::ADDR_SENS, 8'h00); cyc(2);
    chk(ext_irq_req, 4'h0);
    // both active-halt conditions, watchdog armed
    wopt <= 1'b1;
    wact <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      {lt, ov, ch, cl} <= (c == 0) ? 4'b1000 : 4'b0101;
      ex(1'b0); #1 chk(power_mode, lpwk_pkg::LPWK_AHALT);
      chk(osc_on, 1'b1);
      cnt(32); chk(8'(np + nw), 8'd0);
      chk(nt > 0, 1'b1);
      wake(1'b1); chk(power_mode, lpwk_pkg::LPWK_RUN);
    end
    // halt with watchdog option and no active-halt condition
    {lt, ov, ch, cl} <= 4'b0111;
    ex(1'b0); cnt(4);
    chk(power_mode, lpwk_pkg::LPWK_RUN);
    chk(8'(nw), 8'd1);
    // auto-wake halt keeps the start-up wait
    wopt <= 1'b0;
    awu <= 1'b1;
    ex(1'b0); #1 chk(power_mode, lpwk_pkg::LPWK_AWU);
    chk(osc_on, 1'b0);
    wake(1'b1); chk(power_mode, lpwk_pkg::LPWK_START);
    awu <= 1'b0;
    cyc(SU + 4); #1 chk(power_mode, lpwk_pkg::LPWK_RUN);
    results();
  end
  // hang guard, well above the roughly 1300 cycles the tests need
  initial begin
    #40000;
    err_count++;
    results();
  end
endmodule
